/* File: timer_channel_pkg.sv */
// Shared constants and types for the six-channel capture/compare block.
package timer_channel_pkg;

  // Channel count and register map: three byte registers per channel.
  localparam int NUM_CH = 6;
  localparam logic [7:0] BASE_ADDR = 8'h26;
  localparam logic [7:0] REG_STRIDE = 8'h03;
  localparam logic [7:0] REG_SPAN = 8'h12;

  // Register kind within one channel's group of three.
  localparam logic [1:0] KIND_STATUS = 2'h0;
  localparam logic [1:0] KIND_HIGH = 2'h1;
  localparam logic [1:0] KIND_LOW = 2'h2;

  // Reset value of a channel status/control register.
  localparam logic [7:0] STATUS_RST = 8'h00;

  // Edge/level field codes.
  localparam logic [1:0] ELS_OFF = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;

  // Channel status/control layout, bit 7 first.
  typedef struct packed {
    logic channel_event_flag;
    logic channel_irq_enable;
    logic buffered_operation_select;
    logic unbuffered_or_level_select;
    logic [1:0] edge_level_select;
    logic toggle_on_wrap;
    logic full_duty_force;
  } ch_status_s;

  // Decoded register access.
  typedef struct packed {
    logic hit;
    logic [2:0] ch;
    logic [1:0] kind;
  } reg_sel_s;

  // Channel operating modes.
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_BUFFERED
  } ch_mode_e;

endpackage

/* File: timer_channel_capture_compare.sv */
// Six capture/compare channels of a 16-bit timer with their byte register file.
//
// Behaviour
// - Capture edge sets the channel event flag.
// - Counter equal to channel value sets flag.
// - Flag clears by read-with-flag then write 0.
// - Event between read and write keeps flag.
// - Reset clears flag; writing 1 does nothing.
// - Interrupt enable gates requests; reset clears it.
// - Buffered select exists only on even channels.
// - Buffered even channel disables next odd channel.
// - Buffered select overrides unbuffered select; reset clears.
// - Unbuffered select picks capture or compare mode.
// - Edge field zero: select sets initial level.
// - Edge field zero: pin left to port.
// - Capture edges: rising, falling or both.
// - Compare action: toggle, clear or set output.
// - Toggle-on-wrap inverts output at counter overflow.
// - Overflow beats simultaneous compare match.
// - Full-duty with toggle-on-wrap forces 100% duty.
// - Full-duty change applies from next PWM cycle.
// - High byte read blocks captures until low.
// - High byte write blocks compares until low.
// - Overflow pulse marks counter restarting from zero.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/10ps

module timer_channel_capture_compare (
  // Clock and reset.
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  // Register port.
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WR_DATA_I,
  input wire logic WR_EN_I,
  input wire logic RD_EN_I,
  output logic [7:0] RD_DATA_O,
  // Shared counter, same clock domain.
  input wire logic [15:0] COUNT_I,
  input wire logic WRAP_I,
  // Channel pins and requests.
  input wire logic [5:0] CH_PIN_I,
  output logic [5:0] CH_PIN_O,
  output logic [5:0] CH_PIN_OE_O,
  output logic [5:0] CH_IRQ_O
);

  localparam int NCH = timer_channel_pkg::NUM_CH;

  // Map a bus address onto a channel and register kind.
  function automatic timer_channel_pkg::reg_sel_s decode(input logic [7:0] addr);
    logic [7:0] off;
    timer_channel_pkg::reg_sel_s r;
    off = addr - timer_channel_pkg::BASE_ADDR;
    r.hit = (addr >= timer_channel_pkg::BASE_ADDR) && (off < timer_channel_pkg::REG_SPAN);
    r.ch = 3'(off / timer_channel_pkg::REG_STRIDE);
    r.kind = 2'(off % timer_channel_pkg::REG_STRIDE);
    return r;
  endfunction

  // Work out the operating mode from a status/control value.
  function automatic timer_channel_pkg::ch_mode_e mode_of(input timer_channel_pkg::ch_status_s s);
    if (s.edge_level_select == timer_channel_pkg::ELS_OFF) begin
      return timer_channel_pkg::MODE_IDLE;
    end else if (s.buffered_operation_select) begin
      return timer_channel_pkg::MODE_BUFFERED;
    end else if (s.unbuffered_or_level_select) begin
      return timer_channel_pkg::MODE_COMPARE;
    end
    return timer_channel_pkg::MODE_CAPTURE;
  endfunction

  timer_channel_pkg::reg_sel_s sel;
  timer_channel_pkg::ch_status_s wr_st_val;
  timer_channel_pkg::ch_status_s st_q [NCH];
  timer_channel_pkg::ch_mode_e mode_w [NCH];
  logic [15:0] val_q [NCH];
  logic [15:0] cmp_val [NCH];
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic [5:0] pin_d_q;
  logic [5:0] ch_off;
  logic [5:0] cap_ev;
  logic [5:0] cmp_ev;
  logic [5:0] ev;
  logic [5:0] eq_prev_q;
  logic [5:0] armed_q;
  logic [5:0] cap_lock_q;
  logic [5:0] cmp_lock_q;
  logic [5:0] max_eff_q;
  logic [5:0] wr_st;
  logic [5:0] rd_st;
  logic [5:0] wr_hi;
  logic [5:0] wr_lo;
  logic [5:0] rd_hi;
  logic [5:0] rd_lo;
  logic [2:0] buf_half_q;
  logic [2:0] last_odd_q;
  logic [7:0] rd_data_d;

  assign sel = decode(ADDR_I);
  assign wr_st_val = timer_channel_pkg::ch_status_s'(WR_DATA_I);

  // Pins come from outside, so two flops before the edge detector sees them.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
      pin_d_q <= 6'h00;
    end else begin
      pin_s1_q <= CH_PIN_I;
      pin_s2_q <= pin_s1_q;
      pin_d_q <= pin_s2_q;
    end
  end

  // Per-channel strobes, modes, compare values and events.
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      // An odd channel goes dark while its even partner runs buffered.
      ch_off[i] = (i % 2 == 1) && st_q[i - (i % 2)].buffered_operation_select;
      wr_st[i] = WR_EN_I && sel.hit && sel.ch == 3'(i) &&
                 sel.kind == timer_channel_pkg::KIND_STATUS && !ch_off[i];
      rd_st[i] = RD_EN_I && sel.hit && sel.ch == 3'(i) &&
                 sel.kind == timer_channel_pkg::KIND_STATUS && !ch_off[i];
      wr_hi[i] = WR_EN_I && sel.hit && sel.ch == 3'(i) && sel.kind == timer_channel_pkg::KIND_HIGH;
      wr_lo[i] = WR_EN_I && sel.hit && sel.ch == 3'(i) && sel.kind == timer_channel_pkg::KIND_LOW;
      rd_hi[i] = RD_EN_I && sel.hit && sel.ch == 3'(i) && sel.kind == timer_channel_pkg::KIND_HIGH;
      rd_lo[i] = RD_EN_I && sel.hit && sel.ch == 3'(i) && sel.kind == timer_channel_pkg::KIND_LOW;
      mode_w[i] = ch_off[i] ? timer_channel_pkg::MODE_IDLE : mode_of(st_q[i]);
      // Buffered even channels compare against whichever half is active.
      cmp_val[i] = (mode_w[i] == timer_channel_pkg::MODE_BUFFERED && buf_half_q[i / 2]) ?
                   val_q[i | 1] : val_q[i];
      // Bit 0 of the field arms rising edges, bit 1 falling edges.
      cap_ev[i] = mode_w[i] == timer_channel_pkg::MODE_CAPTURE && !cap_lock_q[i] &&
                  ((st_q[i].edge_level_select[0] && pin_s2_q[i] && !pin_d_q[i]) ||
                   (st_q[i].edge_level_select[1] && !pin_s2_q[i] && pin_d_q[i]));
      // Only the first cycle of equality counts, so a slow counter fires once.
      cmp_ev[i] = (mode_w[i] == timer_channel_pkg::MODE_COMPARE ||
                   mode_w[i] == timer_channel_pkg::MODE_BUFFERED) && !cmp_lock_q[i] &&
                  COUNT_I == cmp_val[i] && !eq_prev_q[i];
      ev[i] = cap_ev[i] || cmp_ev[i];
    end
  end

  // Status/control fields and the event flag share one process, since the array has one driver.
  // The flag clears only after a read that saw it set, then a write of zero.
  // A new event always wins, so a request raised mid-sequence is never lost.
  always_ff @(posedge REF_CLK_I) begin
    for (int i = 0; i < NCH; i++) begin
      if (!RST_N_I) begin
        st_q[i][6:0] <= timer_channel_pkg::STATUS_RST[6:0];
        st_q[i].channel_event_flag <= 1'b0;
        armed_q[i] <= 1'b0;
      end else begin
        if (ev[i]) begin
          st_q[i].channel_event_flag <= 1'b1;
          armed_q[i] <= 1'b0;
        end else if (wr_st[i]) begin
          if (armed_q[i] && !wr_st_val.channel_event_flag) begin
            st_q[i].channel_event_flag <= 1'b0;
          end
          armed_q[i] <= 1'b0;
        end else if (rd_st[i] && st_q[i].channel_event_flag) begin
          armed_q[i] <= 1'b1;
        end
      end
      if (RST_N_I && wr_st[i]) begin
        st_q[i].channel_irq_enable <= wr_st_val.channel_irq_enable;
        // Odd channels keep this position reserved and reading zero.
        st_q[i].buffered_operation_select <= (i % 2 == 0) &&
                                             wr_st_val.buffered_operation_select;
        st_q[i].unbuffered_or_level_select <= wr_st_val.unbuffered_or_level_select;
        st_q[i].edge_level_select <= wr_st_val.edge_level_select;
        st_q[i].toggle_on_wrap <= wr_st_val.toggle_on_wrap;
        st_q[i].full_duty_force <= wr_st_val.full_duty_force;
      end
    end
  end

  // Channel values: captures and software byte writes.
  always_ff @(posedge REF_CLK_I) begin
    for (int i = 0; i < NCH; i++) begin
      if (!RST_N_I) begin
        val_q[i] <= 16'h0000;
      end else if (cap_ev[i]) begin
        val_q[i] <= COUNT_I;
      end else if (wr_hi[i]) begin
        val_q[i][15:8] <= WR_DATA_I;
      end else if (wr_lo[i]) begin
        val_q[i][7:0] <= WR_DATA_I;
      end
    end
  end

  // Byte-pair coherency locks for reading captures and writing compare values.
  always_ff @(posedge REF_CLK_I) begin
    for (int i = 0; i < NCH; i++) begin
      if (!RST_N_I) begin
        cap_lock_q[i] <= 1'b0;
        cmp_lock_q[i] <= 1'b0;
        eq_prev_q[i] <= 1'b0;
      end else begin
        eq_prev_q[i] <= COUNT_I == cmp_val[i];
        if (rd_lo[i]) begin
          cap_lock_q[i] <= 1'b0;
        end else if (rd_hi[i] && mode_w[i] == timer_channel_pkg::MODE_CAPTURE) begin
          cap_lock_q[i] <= 1'b1;
        end
        if (wr_lo[i]) begin
          cmp_lock_q[i] <= 1'b0;
        end else if (wr_hi[i] && (st_q[i].buffered_operation_select ||
                                  st_q[i].unbuffered_or_level_select)) begin
          cmp_lock_q[i] <= 1'b1;
        end
      end
    end
  end

  // Buffered pairs: the half written last becomes active at the next overflow,
  // so a new duty value never cuts into a running PWM period.
  always_ff @(posedge REF_CLK_I) begin
    for (int p = 0; p < NCH / 2; p++) begin
      if (!RST_N_I) begin
        last_odd_q[p] <= 1'b0;
        buf_half_q[p] <= 1'b0;
      end else begin
        if (wr_lo[2 * p + 1]) begin
          last_odd_q[p] <= 1'b1;
        end else if (wr_lo[2 * p]) begin
          last_odd_q[p] <= 1'b0;
        end
        if (WRAP_I) begin
          buf_half_q[p] <= last_odd_q[p];
        end
      end
    end
  end

  // Pin level and drive. Overflow toggling outranks a coincident match.
  always_ff @(posedge REF_CLK_I) begin
    for (int i = 0; i < NCH; i++) begin
      if (!RST_N_I) begin
        CH_PIN_O[i] <= 1'b1;
        CH_PIN_OE_O[i] <= 1'b0;
        max_eff_q[i] <= 1'b0;
      end else begin
        // Only compare modes drive the pin; idle or disabled leaves it to the port.
        CH_PIN_OE_O[i] <= mode_w[i] == timer_channel_pkg::MODE_COMPARE ||
                          mode_w[i] == timer_channel_pkg::MODE_BUFFERED;
        if (WRAP_I) begin
          max_eff_q[i] <= st_q[i].full_duty_force;
        end
        if (mode_w[i] == timer_channel_pkg::MODE_IDLE) begin
          CH_PIN_O[i] <= !st_q[i].unbuffered_or_level_select;
        end else if (mode_w[i] == timer_channel_pkg::MODE_CAPTURE) begin
          CH_PIN_O[i] <= CH_PIN_O[i];
        end else if (WRAP_I && st_q[i].toggle_on_wrap) begin
          if (st_q[i].full_duty_force) begin
            // Hold the active level for the whole next period.
            CH_PIN_O[i] <= st_q[i].edge_level_select != timer_channel_pkg::ELS_SET;
          end else begin
            CH_PIN_O[i] <= !CH_PIN_O[i];
          end
        end else if (cmp_ev[i] && !(st_q[i].toggle_on_wrap && max_eff_q[i])) begin
          unique case (st_q[i].edge_level_select)
            timer_channel_pkg::ELS_TOGGLE: CH_PIN_O[i] <= !CH_PIN_O[i];
            timer_channel_pkg::ELS_CLEAR: CH_PIN_O[i] <= 1'b0;
            timer_channel_pkg::ELS_SET: CH_PIN_O[i] <= 1'b1;
            timer_channel_pkg::ELS_OFF: CH_PIN_O[i] <= CH_PIN_O[i];
          endcase
        end
      end
    end
  end

  // Interrupt requests, registered.
  always_ff @(posedge REF_CLK_I) begin
    for (int i = 0; i < NCH; i++) begin
      if (!RST_N_I) begin
        CH_IRQ_O[i] <= 1'b0;
      end else begin
        CH_IRQ_O[i] <= st_q[i].channel_event_flag && st_q[i].channel_irq_enable &&
                       !ch_off[i];
      end
    end
  end

  // Read mux; a disabled odd channel's status and unmapped addresses read zero.
  always_comb begin
    rd_data_d = 8'h00;
    if (RD_EN_I && sel.hit) begin
      unique case (sel.kind)
        timer_channel_pkg::KIND_STATUS: rd_data_d = ch_off[sel.ch] ? 8'h00 : st_q[sel.ch];
        timer_channel_pkg::KIND_HIGH: rd_data_d = val_q[sel.ch][15:8];
        timer_channel_pkg::KIND_LOW: rd_data_d = val_q[sel.ch][7:0];
        default: rd_data_d = 8'h00;
      endcase
    end
  end

  // Read data stands for exactly the cycle after the strobe.
  always_ff @(posedge REF_CLK_I) begin
    if (!RST_N_I) begin
      RD_DATA_O <= 8'h00;
    end else begin
      RD_DATA_O <= rd_data_d;
    end
  end

  // Per-channel checks.
  for (genvar g = 0; g < NCH; g++) begin : g_chk
    capture_flag_a : assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      cap_ev[g] |=> st_q[g].channel_event_flag && val_q[g] == $past(COUNT_I))
      else $error("capture did not set flag and value");
    compare_flag_a : assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      cmp_ev[g] |=> st_q[g].channel_event_flag)
      else $error("compare match did not set flag");
    flag_kept_a : assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (ev[g] && wr_st[g] && !WR_DATA_I[7]) |=> st_q[g].channel_event_flag)
      else $error("flag lost on clearing write");
    write_one_a : assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (!st_q[g].channel_event_flag && !ev[g] && wr_st[g] && WR_DATA_I[7])
      |=> !st_q[g].channel_event_flag)
      else $error("writing one set the flag");
    irq_gate_a : assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (!st_q[g].channel_irq_enable ##1 !st_q[g].channel_irq_enable) |-> !CH_IRQ_O[g])
      else $error("request while enable clear");
    irq_raise_a : assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (st_q[g].channel_event_flag && st_q[g].channel_irq_enable && !ch_off[g]) |=> CH_IRQ_O[g])
      else $error("request missing");
    pin_release_a : assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (mode_w[g] == timer_channel_pkg::MODE_IDLE) |=> !CH_PIN_OE_O[g])
      else $error("idle channel drives pin");
    wrap_toggle_a : assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (WRAP_I && st_q[g].toggle_on_wrap && !st_q[g].full_duty_force &&
       mode_w[g] == timer_channel_pkg::MODE_COMPARE) |=> CH_PIN_O[g] != $past(CH_PIN_O[g]))
      else $error("overflow toggle missed");
    cap_lock_a : assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (cap_lock_q[g] && !wr_hi[g] && !wr_lo[g]) |=> $stable(val_q[g]))
      else $error("capture while locked");
    cmp_lock_a : assert property (
      @(posedge REF_CLK_I) disable iff (!RST_N_I)
      (wr_hi[g] && st_q[g].unbuffered_or_level_select && !wr_lo[g]) |=> !cmp_ev[g])
      else $error("compare after high write");
  end

endmodule

/* File: pin_source_model.sv */
// Behavioural source standing on the far side of the six channel pins.
`timescale 1ns/10ps

module pin_source_model (
  // Levels the external source would put on each pin.
  input wire logic [5:0] level_i,
  // The block's own drive of the pins.
  input wire logic [5:0] dut_pin_i,
  input wire logic [5:0] dut_oe_i,
  // Resolved pin levels seen by the block.
  output logic [5:0] pin_o
);
  // A pin the block drives follows the block, so the source never fights it.
  always_comb begin
    for (int n = 0; n < 6; n++) begin
      pin_o[n] = dut_oe_i[n] ? dut_pin_i[n] : level_i[n];
    end
  end
endmodule

/* File: tb_timer_channel_capture_compare.sv */
// Self-checking bench for the six-channel capture/compare block.
`timescale 1ns/10ps

module tb_timer_channel_capture_compare;
  logic clk;
  logic rst_n = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic wrap = 1'b0;
  logic rd_seen = 1'b0;
  logic p;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] rd_data;
  logic [15:0] count = 16'hFFFF;
  logic [15:0] v;
  logic [15:0] w;
  logic [5:0] pin_lvl = 6'h00;
  logic [5:0] pin_in;
  logic [5:0] pin_out;
  logic [5:0] pin_oe;
  logic [5:0] irq;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int total_checks = 0;

  timer_channel_capture_compare DUT (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WR_DATA_I(wr_data),
    .WR_EN_I(wr_en), .RD_EN_I(rd_en), .RD_DATA_O(rd_data), .COUNT_I(count),
    .WRAP_I(wrap), .CH_PIN_I(pin_in), .CH_PIN_O(pin_out), .CH_PIN_OE_O(pin_oe),
    .CH_IRQ_O(irq)
  );

  pin_source_model partner (
    .level_i(pin_lvl), .dut_pin_i(pin_out), .dut_oe_i(pin_oe), .pin_o(pin_in)
  );

  // Free-running clock at 25 MHz.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // A read notes its expected data; the monitor below compares it later.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  // Counter meets the channel value for a few cycles, then moves on.
  task automatic hit();
    count <= v;
    cyc(3);
    count <= v + 16'h0001;
    cyc(2);
  endtask

  task automatic wrp();
    wrap <= 1'b1;
    cyc(1);
    wrap <= 1'b0;
    cyc(3);
  endtask

  // Read data stand only in the cycle after the strobe, so look exactly there.
  always @(posedge clk) begin
    if (rd_seen) begin
      check(rd_data, exp_q.pop_front());
    end
    rd_seen <= rd_en;
  end

  // A hang is cut short well beyond the expected run length.
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end

  initial begin
    void'($urandom(50));
    cyc(6);
    rst_n <= 1'b1;
    // Status registers come out of reset clear; unmapped places read zero.
    for (int n = 0; n < 6; n++) begin
      rd(8'h26 + 8'(3 * n), timer_channel_pkg::STATUS_RST);
    end
    wr(8'h38, 8'hFF);
    rd(8'h38, 8'h00);
    rd(8'h25, 8'h00);
    // Odd channels lack the buffered bit and vanish behind a buffered partner.
    wr(8'h29, 8'h20);
    rd(8'h29, 8'h00);
    wr(8'h26, 8'h24);
    cyc(2);
    check({7'h00, pin_oe[0]}, 8'h01);
    wr(8'h29, 8'h5C);
    rd(8'h29, 8'h00);
    check({7'h00, pin_oe[1]}, 8'h00);
    rd(8'h26, 8'h24);
    wr(8'h26, 8'h00);
    // Capture on channel 2 for each edge selection; the counter is parked.
    for (int e = 1; e < 4; e++) begin
      cyc(3);
      wr(8'h2C, 8'(e << 2));
      v = 16'($urandom);
      count <= v;
      cyc(2);
      pin_lvl[2] <= 1'b1;
      cyc(6);
      rd(8'h2C, {e != 2, 3'b000, 2'(e), 2'b00});
      if (e != 2) begin
        rd(8'h2D, v[15:8]);
        rd(8'h2E, v[7:0]);
      end
      w = 16'($urandom);
      count <= w;
      pin_lvl[2] <= 1'b0;
      cyc(6);
      rd(8'h2C, {1'b1, 3'b000, 2'(e), 2'b00});
      if (e != 1) begin
        rd(8'h2D, w[15:8]);
        rd(8'h2E, w[7:0]);
      end
      wr(8'h2C, 8'(e << 2));
      rd(8'h2C, 8'(e << 2));
    end
    // A high-byte read freezes the captured value until the low byte is read.
    v = 16'($urandom);
    count <= v;
    pin_lvl[2] <= 1'b1;
    cyc(6);
    rd(8'h2D, v[15:8]);
    count <= ~v;
    pin_lvl[2] <= 1'b0;
    cyc(6);
    rd(8'h2E, v[7:0]);
    rd(8'h2D, v[15:8]);
    rd(8'h2E, v[7:0]);
    // An event between arming read and clearing write keeps the flag.
    rd(8'h2C, 8'h8C);
    pin_lvl[2] <= 1'b1;
    cyc(6);
    wr(8'h2C, 8'h4C);
    cyc(2);
    check({7'h00, irq[2]}, 8'h01);
    rd(8'h2C, 8'hCC);
    wr(8'h2C, 8'h0C);
    cyc(2);
    check({7'h00, irq[2]}, 8'h00);
    // A falling edge sets the flag again so the write-one checks start from a set flag.
    pin_lvl[2] <= 1'b0;
    cyc(6);
    rd(8'h2C, 8'h8C);
    wr(8'h2C, 8'h8C);
    rd(8'h2C, 8'h8C);
    wr(8'h2C, 8'h0C);
    rd(8'h2C, 8'h0C);
    wr(8'h2C, 8'h8C);
    rd(8'h2C, 8'h0C);
    // Compare on channel 0 with a value kept clear of the parked counter.
    v = 16'($urandom) & 16'h7FFF;
    wr(8'h27, v[15:8]);
    wr(8'h28, v[7:0]);
    wr(8'h26, 8'h10);
    cyc(2);
    check({6'h00, pin_oe[0], pin_out[0]}, 8'h00);
    p = 1'b0;
    for (int e = 1; e < 4; e++) begin
      wr(8'h26, 8'h10 | 8'(e << 2));
      cyc(2);
      check({7'h00, pin_oe[0]}, 8'h01);
      hit();
      p = (e == 1) ? ~p : (e == 3);
      check({7'h00, pin_out[0]}, {7'h00, p});
      rd(8'h26, 8'h90 | 8'(e << 2));
    end
    // A lone high-byte write holds off matches until the low byte lands.
    w = v ^ 16'h0100;
    wr(8'h26, 8'h14);
    wr(8'h27, w[15:8]);
    hit();
    rd(8'h26, 8'h14);
    wr(8'h28, w[7:0]);
    v = w;
    hit();
    p = ~p;
    check({7'h00, pin_out[0]}, {7'h00, p});
    rd(8'h26, 8'h94);
    // Overflow toggling, its precedence, and the full-duty latency.
    wr(8'h26, 8'h16);
    count <= v;
    wrp();
    p = ~p;
    check({7'h00, pin_out[0]}, {7'h00, p});
    count <= v + 16'h0001;
    wrp();
    p = ~p;
    check({7'h00, pin_out[0]}, {7'h00, p});
    wr(8'h26, 8'h17);
    hit();
    p = ~p;
    check({7'h00, pin_out[0]}, {7'h00, p});
    wrp();
    check({7'h00, pin_out[0]}, 8'h01);
    hit();
    check({7'h00, pin_out[0]}, 8'h01);
    wr(8'h26, 8'h16);
    hit();
    check({7'h00, pin_out[0]}, 8'h01);
    wrp();
    check({7'h00, pin_out[0]}, 8'h00);
    cyc(4);
    end_sim();
  end
endmodule
